// ===== rtl/bls_regs.sv
// serial register slave of the backlight controller
`timescale 1ns/1ns
module bls_regs (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // interface select strap
  input wire logic interface_select_pin,
  // serial pins
  input wire logic control_or_serial_clock_pin,
  input wire logic reference_or_serial_data_pin_i,
  output logic reference_or_serial_data_pin_o,
  output logic reference_or_serial_data_pin_oe,
  // inverter side
  input wire logic [1:0] inverter_fault_flags,
  output logic [4:0] lamp_level_bits,
  output logic [2:0] power_down_select_bits,
  output logic digital_mode
);
  import bls_pkg::*;

  logic [1:0] rst_pipe_reg;
  logic rst_n;
  bls_bus_s bus;
  bls_state_e state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic rw_reg;
  logic oe_reg;
  logic [7:0] cmd_hold_reg;
  logic [7:0] data_hold_reg;
  logic got_cmd_reg;
  logic got_data_reg;
  logic [7:0] ptr_reg;
  logic [4:0] bright_reg;
  logic [2:0] shmd_reg;
  logic [1:0] stat_s1_reg;
  logic [1:0] stat_s2_reg;
  logic boundary;
  logic commit;
  logic [7:0] rd_byte;

  // ----------------------------------------
  // reset release and pin sampling
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_reg[1];

  bls_pin_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .scl_pin(control_or_serial_clock_pin),
    .sda_pin(reference_or_serial_data_pin_i),
    .mode_pin(interface_select_pin),
    .bus(bus)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_s1_reg <= 2'h0;
      stat_s2_reg <= 2'h0;
    end else begin
      stat_s1_reg <= inverter_fault_flags;
      stat_s2_reg <= stat_s1_reg;
    end
  end

  // ----------------------------------------
  // read data selection
  // ----------------------------------------
  function automatic logic [7:0] read_mux(input logic [7:0] cmd);
    logic [7:0] r;
    r = BLS_FILL_BYTE;
    if (cmd[BLS_CMD_BRIGHT_BIT]) begin
      r = {bright_reg, 1'b1, stat_s2_reg};
    end else if (cmd[7:6] == BLS_CMD_SHMD_SEL) begin
      r = {5'h00, shmd_reg};
    end else begin
      case (cmd[1:0])
        BLS_ID_CHIP_SEL: r = BLS_CHIP_ID;
        BLS_ID_REV_SEL: r = BLS_CHIP_REV;
        BLS_ID_MFR_SEL: r = BLS_MFR_ID;
        default: r = BLS_FILL_BYTE;
      endcase
    end
    return r;
  endfunction

  always_comb begin
    rd_byte = read_mux(ptr_reg);
  end

  assign boundary = bus.fall && (cnt_reg == BLS_CNT_ACK);
  assign commit = (bus.start || bus.stop) && got_cmd_reg && got_data_reg;

  // ----------------------------------------
  // transfer sequencing
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BLS_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'hFF;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (!bus.mode) begin
      state_reg <= BLS_IDLE;
      oe_reg <= 1'b0;
    end else if (bus.start) begin
      state_reg <= BLS_ADDR;
      cnt_reg <= 4'h0;
      oe_reg <= 1'b0;
    end else if (bus.stop) begin
      state_reg <= BLS_IDLE;
      oe_reg <= 1'b0;
    end else if (bus.rise && state_reg != BLS_IDLE && state_reg != BLS_WAIT) begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg < BLS_CNT_BYTE) begin
        shift_reg <= {shift_reg[6:0], bus.sda};
      end else if (state_reg == BLS_TX && bus.sda) begin
        state_reg <= BLS_WAIT;
      end
    end else if (bus.fall) begin
      case (state_reg)
        BLS_ADDR: begin
          if (cnt_reg == BLS_CNT_BYTE) begin
            if (shift_reg[7:1] == BLS_TARGET_ADDR) begin
              oe_reg <= 1'b1;
              rw_reg <= shift_reg[0];
            end else begin
              state_reg <= BLS_WAIT;
            end
          end else if (boundary) begin
            cnt_reg <= 4'h0;
            if (rw_reg) begin
              state_reg <= BLS_TX;
              oe_reg <= ~rd_byte[7];
              tx_reg <= {rd_byte[6:0], 1'b1};
            end else begin
              state_reg <= BLS_CMD;
              oe_reg <= 1'b0;
            end
          end
        end
        BLS_CMD, BLS_DATA: begin
          if (cnt_reg == BLS_CNT_BYTE) begin
            oe_reg <= 1'b1;
          end else if (boundary) begin
            cnt_reg <= 4'h0;
            oe_reg <= 1'b0;
            state_reg <= (state_reg == BLS_CMD) ? BLS_DATA : BLS_WAIT;
          end
        end
        BLS_TX: begin
          if (cnt_reg == BLS_CNT_BYTE) begin
            oe_reg <= 1'b0;
          end else if (boundary) begin
            cnt_reg <= 4'h0;
            oe_reg <= ~BLS_FILL_BYTE[7];
            tx_reg <= {BLS_FILL_BYTE[6:0], 1'b1};
          end else begin
            oe_reg <= ~tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b1};
          end
        end
        default: oe_reg <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // pending command and data bytes
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_hold_reg <= BLS_CMD_POR;
      data_hold_reg <= 8'h00;
      got_cmd_reg <= 1'b0;
      got_data_reg <= 1'b0;
    end else if (bus.start || bus.stop || !bus.mode) begin
      got_cmd_reg <= 1'b0;
      got_data_reg <= 1'b0;
    end else if (bus.fall && cnt_reg == BLS_CNT_BYTE && state_reg == BLS_CMD) begin
      cmd_hold_reg <= shift_reg;
      got_cmd_reg <= 1'b1;
    end else if (bus.fall && cnt_reg == BLS_CNT_BYTE && state_reg == BLS_DATA) begin
      data_hold_reg <= shift_reg;
      got_data_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // command pointer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg <= BLS_CMD_POR;
    end else if (got_cmd_reg && (commit || bus.start)) begin
      ptr_reg <= cmd_hold_reg;
    end
  end

  // ----------------------------------------
  // functional registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bright_reg <= BLS_BRIGHT_POR;
      shmd_reg <= BLS_SHMD_POR;
    end else if (commit) begin
      if (cmd_hold_reg[BLS_CMD_BRIGHT_BIT]) begin
        bright_reg <= data_hold_reg[BLS_BRIGHT_LSB +: 5];
      end else if (cmd_hold_reg[7:6] == BLS_CMD_SHMD_SEL) begin
        shmd_reg <= data_hold_reg[BLS_SHMD_LSB +: 3];
      end
    end
  end

  assign reference_or_serial_data_pin_o = 1'b0;
  assign reference_or_serial_data_pin_oe = oe_reg;
  assign lamp_level_bits = bright_reg;
  assign power_down_select_bits = shmd_reg;
  assign digital_mode = bus.mode;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_write_end;
    (bus.start || bus.stop) && got_cmd_reg && got_data_reg;
  endsequence

  sequence s_addr_byte;
    state_reg == BLS_ADDR && bus.fall && cnt_reg == BLS_CNT_BYTE && !bus.start && !bus.stop && bus.mode;
  endsequence

  analog_release_a: assert property (@(posedge clk) disable iff (!rst_n) !bus.mode |=> !oe_reg)
    else $error("data pin driven outside digital mode");
  start_to_addr_a: assert property (@(posedge clk) disable iff (!rst_n) bus.start && bus.mode |=> state_reg == BLS_ADDR)
    else $error("start not followed by address phase");
  addr_match_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_addr_byte ##0 shift_reg[7:1] == BLS_TARGET_ADDR |=> oe_reg ##0 state_reg == BLS_ADDR)
    else $error("own address not acknowledged");
  addr_miss_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_addr_byte ##0 shift_reg[7:1] != BLS_TARGET_ADDR |=> !oe_reg ##0 state_reg == BLS_WAIT)
    else $error("foreign address acknowledged");
  bright_commit_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_write_end ##0 cmd_hold_reg[7] |=> bright_reg == $past(data_hold_reg[7:3]))
    else $error("brightness not written");
  shmd_commit_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_write_end ##0 cmd_hold_reg[7:6] == 2'h1 |=> shmd_reg == $past(data_hold_reg[2:0]))
    else $error("shutdown mode not written");
  regs_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(bus.start || bus.stop) |=> $stable(bright_reg) && $stable(shmd_reg))
    else $error("register changed outside stop or restart");
  early_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.start || bus.stop) && !got_data_reg |=> $stable(bright_reg) && $stable(shmd_reg))
    else $error("incomplete write changed a register");
  ptr_por_a: assert property (@(posedge clk) $rose(rst_n) |-> ptr_reg == BLS_CMD_POR)
    else $error("command pointer not at power-on value");
  tx_first_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == BLS_ADDR && boundary && rw_reg && bus.mode && !bus.start && !bus.stop
    |=> state_reg == BLS_TX ##0 oe_reg == ~$past(rd_byte[7]))
    else $error("read data first bit wrong");

endmodule

// ===== rtl/bls_pkg.sv
// constants and types of the backlight serial register slave
//
// Functional notes
// - strap high turns pins into serial bus
// - data pin bidirectional, clock pin is input
// - write-byte, read-byte, receive-byte formats supported
// - target only, never drives the clock
// - answer address 0101101 only, write byte 5A
// - five-bit brightness register, write and read
// - three-bit shutdown mode register, write and read
// - two-bit status register reports inverter state
// - three read-only eight-bit identification registers
// - early start or stop discards transfer data
// - registers update only at stop or restart
// - receive-byte uses last command, reset 80
package bls_pkg;

  // ----------------------------------------
  // bus addressing and commands
  // ----------------------------------------
  localparam logic [6:0] BLS_TARGET_ADDR = 7'h2D;
  localparam logic [7:0] BLS_CMD_POR = 8'h80;
  localparam int BLS_CMD_BRIGHT_BIT = 7;
  localparam logic [1:0] BLS_CMD_SHMD_SEL = 2'h1;
  localparam logic [1:0] BLS_ID_CHIP_SEL = 2'h0;
  localparam logic [1:0] BLS_ID_REV_SEL = 2'h1;
  localparam logic [1:0] BLS_ID_MFR_SEL = 2'h2;
  localparam logic [7:0] BLS_FILL_BYTE = 8'hFF;

  // ----------------------------------------
  // identification values (arbitrary)
  // ----------------------------------------
  localparam logic [7:0] BLS_CHIP_ID = 8'h3C;
  localparam logic [7:0] BLS_CHIP_REV = 8'h01;
  localparam logic [7:0] BLS_MFR_ID = 8'hA5;

  // ----------------------------------------
  // field layout and reset values
  // ----------------------------------------
  localparam int BLS_BRIGHT_LSB = 3;
  localparam int BLS_SHMD_LSB = 0;
  localparam logic [4:0] BLS_BRIGHT_POR = 5'h00;
  localparam logic [2:0] BLS_SHMD_POR = 3'h0;

  // ----------------------------------------
  // bit counting per byte
  // ----------------------------------------
  localparam logic [3:0] BLS_CNT_BYTE = 4'h8;
  localparam logic [3:0] BLS_CNT_ACK = 4'h9;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    BLS_IDLE = 3'h0,
    BLS_ADDR = 3'h1,
    BLS_CMD = 3'h3,
    BLS_DATA = 3'h2,
    BLS_TX = 3'h6,
    BLS_WAIT = 3'h7
  } bls_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
    logic mode;
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } bls_bus_s;

endpackage

// ===== rtl/bls_pin_sync.sv
// pin synchroniser and bus condition detector
`timescale 1ns/1ns
module bls_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic mode_pin,
  // synchronised view
  output bls_pkg::bls_bus_s bus
);
  import bls_pkg::*;

  logic [2:0] stage1_reg;
  logic [2:0] stage2_reg;
  logic [2:0] prev_reg;

  // ----------------------------------------
  // two-flop synchroniser plus history
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= 3'h7;
      stage2_reg <= 3'h7;
      prev_reg <= 3'h7;
    end else begin
      stage1_reg <= {mode_pin, sda_pin, scl_pin};
      stage2_reg <= stage1_reg;
      prev_reg <= stage2_reg;
    end
  end

  // ----------------------------------------
  // start, stop and clock edges
  // ----------------------------------------
  always_comb begin
    bus.scl = stage2_reg[0];
    bus.sda = stage2_reg[1];
    bus.mode = stage2_reg[2];
    bus.start = prev_reg[0] & stage2_reg[0] & prev_reg[1] & ~stage2_reg[1];
    bus.stop = prev_reg[0] & stage2_reg[0] & ~prev_reg[1] & stage2_reg[1];
    bus.rise = ~prev_reg[0] & stage2_reg[0];
    bus.fall = prev_reg[0] & ~stage2_reg[0];
  end

endmodule

// ===== tb/bls_host.sv
// host model of the serial bus: drives the clock and pulls the data line
`timescale 1ns/1ns
module bls_host #(
  parameter int QTR = 2
) (
  // clock
  input wire logic clk,
  // bus lines
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // ----------------------------------------
  // line drivers
  // ----------------------------------------
  // bit time is 4 quarters of 2 clk, so 160 ns
  // each clock phase lasts 4 clk, the shortest the slave follows
  // data changes 2 clk after a clock fall, ahead of the next rise
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic gap;
    repeat (QTR) @(posedge clk);
  endtask

  // data set while clock low, sampled in mid high phase
  task automatic bitx(input logic b, output logic r);
    gap();
    sda_pull <= ~b;
    gap();
    scl <= 1'b1;
    gap();
    r = sda_line;
    gap();
    scl <= 1'b0;
  endtask

  // ----------------------------------------
  // framing
  // ----------------------------------------
  task automatic start;
    gap();
    sda_pull <= 1'b0;
    gap();
    scl <= 1'b1;
    gap();
    sda_pull <= 1'b1;
    gap();
    scl <= 1'b0;
  endtask

  task automatic stop;
    gap();
    sda_pull <= 1'b1;
    gap();
    scl <= 1'b1;
    gap();
    sda_pull <= 1'b0;
    gap();
  endtask

  // msb first, ninth bit carries the acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, r);
    ack = ~r;
  endtask

  // read a byte, then answer with not-acknowledge
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, d[i]);
    end
    bitx(1'b1, r);
  endtask
endmodule

// ===== tb/bls_regs_tb.sv
// self-checking bench of the backlight serial register slave
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module bls_regs_tb;
  import bls_pkg::*;
  logic clk, nrst, strap, sda_o, sda_oe, dmode, a;
  logic [1:0] flags;
  logic [4:0] lamp;
  logic [2:0] shd;
  logic [7:0] rd;
  wire logic scl, sda_pull, sda_line;
  int fail_count, n_checks;
  localparam logic [7:0] IDS [4] = '{BLS_CHIP_ID, BLS_CHIP_REV, BLS_MFR_ID, BLS_FILL_BYTE};

  // ----------------------------------------
  // wiring, pull-up on the data line
  // ----------------------------------------
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_o));
  bls_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));
  bls_regs dut (.clk(clk), .nrst(nrst), .interface_select_pin(strap),
    .control_or_serial_clock_pin(scl), .reference_or_serial_data_pin_i(sda_line),
    .reference_or_serial_data_pin_o(sda_o), .reference_or_serial_data_pin_oe(sda_oe),
    .inverter_fault_flags(flags), .lamp_level_bits(lamp), .power_down_select_bits(shd),
    .digital_mode(dmode));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------
  // transaction tasks
  // ----------------------------------------
  task automatic print_verdict;
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic addr(input logic [7:0] b);
    host.start();
    host.wbyte(b, a);
    `CHK("addr_ack", 1'b1, a)
  endtask

  task automatic fin;
    host.stop();
    repeat (6) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    addr(8'h5A);
    host.wbyte(c, a);
    `CHK("cmd_ack", 1'b1, a)
    host.wbyte(d, a);
    `CHK("data_ack", 1'b1, a)
  endtask

  task automatic rdb(input logic [7:0] c, output logic [7:0] d);
    addr(8'h5A);
    host.wbyte(c, a);
    `CHK("cmd_ack", 1'b1, a)
    addr(8'h5B);
    host.rbyte(d);
    fin();
  endtask

  task automatic rcv(output logic [7:0] d);
    addr(8'h5B);
    host.rbyte(d);
    fin();
  endtask

  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  initial begin
    nrst = 1'b0;
    strap = 1'b1;
    flags = 2'h2;
    fail_count = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("lamp_por", 5'h00, lamp)
    `CHK("shd_por", 3'h0, shd)
    `CHK("mode", 1'b1, dmode)
    rcv(rd);
    `CHK("rcv_por", 8'h06, rd)
    wr(8'h80, 8'hAB);
    `CHK("lamp_early", 5'h00, lamp)
    fin();
    `CHK("lamp", 5'h15, lamp)
    flags <= 2'h1;
    rdb(8'h80, rd);
    `CHK("bright_rd", 8'hAD, rd)
    wr(8'h40, 8'hFD);
    fin();
    `CHK("shd", 3'h5, shd)
    rdb(8'h40, rd);
    `CHK("shd_rd", 8'h05, rd)
    rcv(rd);
    `CHK("rcv_ptr", 8'h05, rd)
    for (int i = 0; i < 4; i++) begin
      rdb({6'h00, i[1:0]}, rd);
      `CHK("id", IDS[i], rd)
    end
    host.start();
    host.wbyte(8'h5C, a);
    `CHK("foreign_addr", 1'b0, a)
    fin();
    addr(8'h5A);
    host.wbyte(8'h80, a);
    for (int i = 0; i < 4; i++) begin
      host.bitx(1'b0, a);
    end
    fin();
    `CHK("lamp_abort", 5'h15, lamp)
    rcv(rd);
    `CHK("ptr_abort", BLS_FILL_BYTE, rd)
    strap <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("mode_off", 1'b0, dmode)
    host.start();
    host.wbyte(8'h5A, a);
    `CHK("analog_ack", 1'b0, a)
    fin();
    print_verdict();
  end
endmodule
